// *** reset_source_and_watchdog.sv ***
/*
 * Reset controller: collects supply-monitor, pin, missing-clock, comparator,
 * convert-start and watchdog reset requests, sequences the core reset,
 * records the cause and hosts the watchdog.
 * Assumes all request pins are asynchronous to clk_in, rst_b_in is the
 * power-on reset, and the /RST pin is open drain with an external pull-up.
 */
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - in reset: core halted, registers at reset values, pins known, interrupts and timers off
// - data memory is write-blocked through reset; contents undefined after power-on
// - port latches preset to all ones during and after reset
// - supply-monitor resets drive /RST low until the 100 ms timeout ends
// - on exit PC cleared, slowest internal oscillator; fetch from zero once clock stable
// - every reset leaves the watchdog enabled with the longest interval
// - supply monitor acts only with enable pin high and enable bit 1 set
// - power-on exit sets power-on flag; any other reset clears it
// - supply below threshold drives /RST low and resets like power-on
// - low /RST resets; release plus 12 cycles, then pin flag set
// - missing clock detector, enabled by bit 2, resets without driving /RST
// - comparator reset enable bit 5: low comparator output resets, pin untouched
// - convert-start reset enable bit 6: low input resets and stops starting conversions
// - 21-bit watchdog counter resets the device when its limit is exceeded
// - writing 0xa5 enables the watchdog and restarts its count
// - watchdog disabled only by 0xde then 0xad within 4 cycles
// - writing 0xff locks out disabling until reset, without kicking
// - timeout is 4^(3+interval) cycles; interval reads back, resets to 111b
// - interval written only when bit 7 is zero; bit 4 reads watchdog active
module reset_source_and_watchdog
    import reset_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_TIMEOUT_CYCLES
)
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic supply_ok_in,
    input wire logic supply_monitor_enable_pin_in,
    input wire logic reset_pin_b_in,
    input wire logic comparator_high_in,
    input wire logic convert_start_input_b_in,
    input wire logic clock_missing_in,
    input wire logic clock_stable_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    output logic reset_pin_out,
    output logic reset_pin_oe_out,
    output logic core_reset_b_out,
    output logic port_latch_preset_out,
    output logic ram_write_block_out,
    output logic osc_default_out,
    output logic fetch_enable_out,
    output logic convert_start_b_out
);

    localparam logic [POR_CNT_WIDTH-1:0] POR_LAST = POR_CNT_WIDTH'(POR_CYCLES - 1);
    localparam logic [POR_CNT_WIDTH-1:0] STRETCH_LAST = POR_CNT_WIDTH'(PIN_STRETCH_CYCLES - 1);
    localparam int unsigned SYNC_W = $bits(async_in_t);

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    function automatic logic [7:0] source_byte(input cause_t f);
        logic [7:0] b;
        b = RESET_SOURCE_RESET;
        b[PIN_FLAG_BIT] = f.pin;
        b[POR_FLAG_BIT] = f.por;
        b[MCD_FLAG_BIT] = f.mcd;
        b[WDT_FLAG_BIT] = f.wdt;
        b[COMP_FLAG_BIT] = f.comp;
        b[CONV_FLAG_BIT] = f.conv;
        source_byte = b;
    endfunction

    // synchronisers for every pin-level request
    async_in_t raw_in;
    async_in_t sync_in;
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;

    assign raw_in.supply_ok = supply_ok_in;
    assign raw_in.monitor_en = supply_monitor_enable_pin_in;
    assign raw_in.pin_b = reset_pin_b_in;
    assign raw_in.comp_high = comparator_high_in;
    assign raw_in.conv_b = convert_start_input_b_in;
    assign raw_in.clk_missing = clock_missing_in;
    assign raw_in.clk_stable = clock_stable_in;

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end else begin
                    meta_q[gi] <= raw_in[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    assign sync_in = async_in_t'(sync_q);

    // state and software-visible bits
    rst_state_t state_q;
    rst_state_t state_d;
    cause_t cause_q;
    cause_t cause_d;
    cause_t flags_q;
    logic [POR_CNT_WIDTH-1:0] cnt_q;
    logic supply_en_q;
    logic mcd_en_q;
    logic comp_en_q;
    logic conv_en_q;
    logic in_reset_q;
    logic wdt_expire;
    logic wdt_active;
    logic [2:0] wdt_interval;
    logic supply_fail;
    logic running;
    logic src_wr;
    logic wdt_wr;

    assign running = (state_q == ST_RUN);
    assign src_wr = wr_in && running && hit(addr_in, ADDR_RESET_SOURCE);
    assign wdt_wr = wr_in && running && hit(addr_in, ADDR_WATCHDOG_CTRL);
    assign supply_fail = sync_in.monitor_en && supply_en_q && !sync_in.supply_ok;

    always_comb begin
        state_d = state_q;
        cause_d = cause_q;
        if (supply_fail) begin
            state_d = ST_POR;
            cause_d = '{por: 1'b1, default: 1'b0};
        end else begin
            case (state_q)
                ST_POR: begin
                    if (cnt_q == POR_LAST) begin
                        // stretch covers the echo of our own pin drive through the synchroniser
                        state_d = ST_STRETCH;
                    end
                end
                ST_PIN: begin
                    if (sync_in.pin_b) begin
                        state_d = ST_STRETCH;
                    end
                end
                ST_STRETCH: begin
                    if (cnt_q == STRETCH_LAST) begin
                        state_d = ST_CLKWAIT;
                    end
                end
                ST_CLKWAIT: begin
                    if (!sync_in.pin_b) begin
                        state_d = ST_PIN;
                        cause_d = '{pin: 1'b1, default: 1'b0};
                    end else if (sync_in.clk_stable) begin
                        state_d = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!sync_in.pin_b) begin
                        state_d = ST_PIN;
                        cause_d = '{pin: 1'b1, default: 1'b0};
                    end else if (mcd_en_q && sync_in.clk_missing) begin
                        state_d = ST_STRETCH;
                        cause_d = '{mcd: 1'b1, default: 1'b0};
                    end else if (wdt_expire) begin
                        state_d = ST_STRETCH;
                        cause_d = '{wdt: 1'b1, default: 1'b0};
                    end else if (comp_en_q && !sync_in.comp_high) begin
                        state_d = ST_STRETCH;
                        cause_d = '{comp: 1'b1, default: 1'b0};
                    end else if (conv_en_q && !sync_in.conv_b) begin
                        state_d = ST_STRETCH;
                        cause_d = '{conv: 1'b1, default: 1'b0};
                    end
                end
                default: begin
                    state_d = ST_POR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= ST_POR;
            cause_q <= '{por: 1'b1, default: 1'b0};
        end else begin
            state_q <= state_d;
            cause_q <= cause_d;
        end
    end

    // one counter serves the supply timeout and the release stretch
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q <= '0;
        end else if (state_d != state_q || supply_fail) begin
            cnt_q <= '0;
        end else if (state_q == ST_POR || state_q == ST_STRETCH) begin
            cnt_q <= cnt_q + POR_CNT_WIDTH'(1);
        end
    end

    // flags change only when the release stretch ends, before the clock wait
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flags_q <= '0;
        end else if (state_q == ST_STRETCH && state_d == ST_CLKWAIT) begin
            flags_q <= cause_q;
        end
    end

    // enables clear on any reset entry; the supply enable comes back set
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            supply_en_q <= 1'b1;
            mcd_en_q <= 1'b0;
            comp_en_q <= 1'b0;
            conv_en_q <= 1'b0;
        end else if (!running) begin
            supply_en_q <= 1'b1;
            mcd_en_q <= 1'b0;
            comp_en_q <= 1'b0;
            conv_en_q <= 1'b0;
        end else if (src_wr) begin
            supply_en_q <= wdata_in[POR_FLAG_BIT];
            mcd_en_q <= wdata_in[MCD_FLAG_BIT];
            comp_en_q <= wdata_in[COMP_FLAG_BIT];
            conv_en_q <= wdata_in[CONV_FLAG_BIT];
        end
    end

    watchdog_timer watchdog_timer_inst (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .sys_reset_in(in_reset_q),
        .wr_in(wdt_wr),
        .wdata_in(wdata_in),
        .expire_out(wdt_expire),
        .active_out(wdt_active),
        .interval_out(wdt_interval)
    );

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in && hit(addr_in, ADDR_RESET_SOURCE)) begin
            rdata_out <= source_byte(flags_q);
        end else if (rd_in && hit(addr_in, ADDR_WATCHDOG_CTRL)) begin
            rdata_out <= {3'h0, wdt_active, 1'b0, wdt_interval};
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // core-facing controls, all released on a clock edge
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            in_reset_q <= 1'b1;
            core_reset_b_out <= 1'b0;
            port_latch_preset_out <= 1'b1;
            ram_write_block_out <= 1'b1;
            osc_default_out <= 1'b1;
            fetch_enable_out <= 1'b0;
        end else begin
            in_reset_q <= (state_d != ST_RUN);
            core_reset_b_out <= (state_d == ST_RUN);
            port_latch_preset_out <= (state_d != ST_RUN);
            ram_write_block_out <= (state_d != ST_RUN);
            osc_default_out <= (state_d != ST_RUN);
            fetch_enable_out <= (state_d == ST_RUN);
        end
    end

    // open drain /RST: driven low only for power-on and supply-monitor resets
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reset_pin_out <= 1'b0;
            reset_pin_oe_out <= 1'b1;
        end else begin
            reset_pin_out <= 1'b0;
            reset_pin_oe_out <= (state_d == ST_POR);
        end
    end

    // a convert-start pin used as a reset no longer triggers conversions
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            convert_start_b_out <= 1'b1;
        end else begin
            convert_start_b_out <= conv_en_q ? 1'b1 : sync_in.conv_b;
        end
    end

endmodule // reset_source_and_watchdog

`default_nettype wire

// *** reset_pkg.sv ***
/*
 * Shared constants, field positions and carrier types for the reset source
 * controller and its watchdog.
 * Assumes a single 20 MHz system clock and an 8-bit register port.
 */
`default_nettype none

package reset_pkg;

    // system clock and timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned POR_TIMEOUT_MS = 100;
    localparam int unsigned POR_TIMEOUT_CYCLES = (CLK_HZ / 1000) * POR_TIMEOUT_MS;
    localparam int unsigned POR_CNT_WIDTH = 21;
    localparam int unsigned PIN_STRETCH_CYCLES = 12;
    localparam logic [2:0] WDT_DISARM_WINDOW = 3'h4;
    localparam int unsigned WDT_WIDTH = 21;

    // register offsets
    localparam logic [7:0] ADDR_RESET_SOURCE = 8'hef;
    localparam logic [7:0] ADDR_WATCHDOG_CTRL = 8'hff;

    // reset_source_register fields
    localparam int unsigned PIN_FLAG_BIT = 0;
    localparam int unsigned POR_FLAG_BIT = 1;
    localparam int unsigned MCD_FLAG_BIT = 2;
    localparam int unsigned WDT_FLAG_BIT = 3;
    localparam int unsigned COMP_FLAG_BIT = 5;
    localparam int unsigned CONV_FLAG_BIT = 6;

    // watchdog_control_register fields and commands
    localparam int unsigned WDT_ACTIVE_BIT = 4;
    localparam int unsigned WDT_NO_INTERVAL_BIT = 7;
    localparam logic [7:0] WDT_CMD_KICK = 8'ha5;
    localparam logic [7:0] WDT_CMD_DISARM1 = 8'hde;
    localparam logic [7:0] WDT_CMD_DISARM2 = 8'had;
    localparam logic [7:0] WDT_CMD_LOCK = 8'hff;

    // reset values
    localparam logic [7:0] RESET_SOURCE_RESET = 8'h00;
    localparam logic [2:0] WDT_INTERVAL_RESET = 3'h7;

    typedef struct packed {
        logic conv;
        logic comp;
        logic wdt;
        logic mcd;
        logic por;
        logic pin;
    } cause_t;

    typedef struct packed {
        logic supply_ok;
        logic monitor_en;
        logic pin_b;
        logic comp_high;
        logic conv_b;
        logic clk_missing;
        logic clk_stable;
    } async_in_t;

    typedef enum logic [2:0] {
        ST_POR,
        ST_PIN,
        ST_STRETCH,
        ST_CLKWAIT,
        ST_RUN
    } rst_state_t;

endpackage

`default_nettype wire

// *** watchdog_timer.sv ***
/*
 * Watchdog: 21-bit counter on the system clock with kick, two-write
 * disable, disable lockout and interval selection.
 * Assumes sys_reset_in is a synchronous level from the reset controller.
 */
`timescale 1ns/1ns
`default_nettype none

module watchdog_timer
    import reset_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic sys_reset_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    output logic expire_out,
    output logic active_out,
    output logic [2:0] interval_out
);

    logic [WDT_WIDTH-1:0] count_q;
    logic active_q;
    logic locked_q;
    logic [2:0] interval_q;
    logic [2:0] arm_q;
    logic expire_q;
    logic [WDT_WIDTH-1:0] last_count;

    // 4^(3+iv) periods is 2^(6+2*iv); the top interval's last count fills 20 bits exactly
    function automatic logic [WDT_WIDTH-1:0] timeout_last(input logic [2:0] iv);
        logic [WDT_WIDTH:0] span;
        span = (WDT_WIDTH+1)'(1) << (6 + 2 * int'(iv));
        timeout_last = WDT_WIDTH'(span - (WDT_WIDTH+1)'(1));
    endfunction

    assign last_count = timeout_last(interval_q);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_q <= '0;
        end else if (sys_reset_in || !active_q) begin
            count_q <= '0;
        end else if (wr_in && wdata_in == WDT_CMD_KICK) begin
            count_q <= '0;
        end else if (count_q < last_count) begin
            count_q <= count_q + WDT_WIDTH'(1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            expire_q <= 1'b0;
        end else begin
            // >= so that shortening the interval past the count still fires
            expire_q <= active_q && !sys_reset_in && count_q >= last_count;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            active_q <= 1'b1;
        end else if (sys_reset_in) begin
            active_q <= 1'b1;
        end else if (wr_in && wdata_in == WDT_CMD_KICK) begin
            active_q <= 1'b1;
        end else if (wr_in && wdata_in == WDT_CMD_DISARM2 && arm_q != 3'h0 && !locked_q) begin
            active_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            arm_q <= 3'h0;
        end else if (sys_reset_in || locked_q) begin
            arm_q <= 3'h0;
        end else if (wr_in && wdata_in == WDT_CMD_DISARM1) begin
            arm_q <= WDT_DISARM_WINDOW;
        end else if (arm_q != 3'h0) begin
            arm_q <= arm_q - 3'h1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            locked_q <= 1'b0;
        end else if (sys_reset_in) begin
            locked_q <= 1'b0;
        end else if (wr_in && wdata_in == WDT_CMD_LOCK) begin
            locked_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            interval_q <= WDT_INTERVAL_RESET;
        end else if (sys_reset_in) begin
            interval_q <= WDT_INTERVAL_RESET;
        end else if (wr_in && !wdata_in[WDT_NO_INTERVAL_BIT]) begin
            interval_q <= wdata_in[2:0];
        end
    end

    assign expire_out = expire_q;
    assign active_out = active_q;
    assign interval_out = interval_q;

endmodule // watchdog_timer

`default_nettype wire

// *** reset_source_and_watchdog_properties.sv ***
/*
 * Port checker for the reset controller: reset outputs, /RST drive, stretch and release.
 * Assumes the design's top ports only; bound at the foot of this file.
 */
`timescale 1ns/1ns
`default_nettype none

module reset_source_and_watchdog_properties
    import reset_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_TIMEOUT_CYCLES
)
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic supply_ok_in,
    input wire logic supply_monitor_enable_pin_in,
    input wire logic reset_pin_b_in,
    input wire logic clock_stable_in,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_out,
    input wire logic core_reset_b_out,
    input wire logic port_latch_preset_out,
    input wire logic ram_write_block_out,
    input wire logic osc_default_out,
    input wire logic fetch_enable_out
);
    logic [4:0] pin_hi_q;
    int unsigned oe_len_q;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    // saturating run length of a high /RST wire
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_hi_q <= 5'h00;
        end else if (!reset_pin_b_in) begin
            pin_hi_q <= 5'h00;
        end else if (pin_hi_q != 5'h1f) begin
            pin_hi_q <= pin_hi_q + 5'h01;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            oe_len_q <= 0;
        end else begin
            oe_len_q <= reset_pin_oe_out ? oe_len_q + 1 : 0;
        end
    end

    a_latch_preset: assert property (!core_reset_b_out |-> port_latch_preset_out)
        else $error("port latches not preset in reset");
    a_ram_blocked: assert property (!core_reset_b_out |-> ram_write_block_out)
        else $error("memory writes open in reset");
    a_osc_default: assert property (!core_reset_b_out |-> osc_default_out)
        else $error("oscillator default missing in reset");
    a_fetch_tracks: assert property (fetch_enable_out == core_reset_b_out)
        else $error("fetch enable differs from core run");
    a_pin_low_only: assert property (reset_pin_oe_out |-> !reset_pin_out)
        else $error("reset pin driven high");
    a_oe_in_reset: assert property (reset_pin_oe_out |=> !core_reset_b_out)
        else $error("reset pin driven while core runs");
    a_por_timeout: assert property ($fell(reset_pin_oe_out) |-> oe_len_q >= POR_CYCLES - 1)
        else $error("reset pin released before timeout");
    a_supply_fail: assert property ($fell(supply_ok_in) && supply_monitor_enable_pin_in
        |-> ##[1:6] reset_pin_oe_out) else $error("supply fail did not drive reset pin");
    a_pin_enters: assert property ($fell(reset_pin_b_in) && core_reset_b_out
        |-> ##[1:6] !core_reset_b_out) else $error("low reset pin ignored");
    a_stretch_min: assert property ($rose(core_reset_b_out) |-> pin_hi_q >= 5'h0c)
        else $error("reset left under twelve cycles after pin release");
    a_release_clock: assert property ($rose(core_reset_b_out)
        |-> $past(clock_stable_in) && $past(clock_stable_in, 2)) else $error("run before clock stable");
endmodule // reset_source_and_watchdog_properties

bind reset_source_and_watchdog reset_source_and_watchdog_properties #(
    .POR_CYCLES(POR_CYCLES)
) props_inst (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .supply_ok_in(supply_ok_in),
    .supply_monitor_enable_pin_in(supply_monitor_enable_pin_in), .reset_pin_b_in(reset_pin_b_in),
    .clock_stable_in(clock_stable_in), .reset_pin_out(reset_pin_out), .reset_pin_oe_out(reset_pin_oe_out),
    .core_reset_b_out(core_reset_b_out), .port_latch_preset_out(port_latch_preset_out),
    .ram_write_block_out(ram_write_block_out), .osc_default_out(osc_default_out),
    .fetch_enable_out(fetch_enable_out)
);

`default_nettype wire

// *** reset_far_side.sv ***
/*
 * Far side of the reset pins: /RST wire with pull-up and push button, and an
 * oscillator that settles some cycles after each reset entry.
 * Assumes the controller's clock.
 */
`timescale 1ns/1ns
`default_nettype none

module reset_far_side (
    input wire logic clk_in,
    input wire logic press_in,
    input wire logic pin_oe_in,
    input wire logic pin_drive_in,
    input wire logic core_reset_b_in,
    output logic reset_pin_b_out,
    output logic clock_stable_out
);
    logic [3:0] settle_q = 4'h0;

    // open drain: the pull-up wins unless button or controller pulls low
    assign reset_pin_b_out = !(press_in || (pin_oe_in && !pin_drive_in));

    always @(posedge clk_in) begin
        if (core_reset_b_in) begin
            settle_q <= 4'h0;
        end else if (!settle_q[3]) begin
            settle_q <= settle_q + 4'h1;
        end
    end

    // each reset restarts the oscillator, so fetch has to wait for it
    assign clock_stable_out = core_reset_b_in || settle_q[3];
endmodule // reset_far_side

`default_nettype wire

// *** reset_source_and_watchdog_tb_top.sv ***
/*
 * Bench for the reset controller: power-on, every reset source, watchdog commands.
 * Assumes reset_far_side models the /RST wire and oscillator settling.
 */
`timescale 1ns/1ns
`default_nettype none

module reset_source_and_watchdog_tb_top
    import reset_pkg::*;
;
    logic clk_in, rst_b_in, sok, mon, pin_b, cmp, cnv, miss, stab, wr, rd, press;
    logic [7:0] addr, wdata, rdata;
    logic drv, oe, core_b, cnv_out;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    int oe_cnt = 0;
    int srcs[5] = '{0, 1, 2, 5, 6};

    reset_source_and_watchdog #(.POR_CYCLES(50)) reset_source_and_watchdog_inst (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .supply_ok_in(sok), .supply_monitor_enable_pin_in(mon),
        .reset_pin_b_in(pin_b), .comparator_high_in(cmp), .convert_start_input_b_in(cnv),
        .clock_missing_in(miss), .clock_stable_in(stab), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .reset_pin_out(drv), .reset_pin_oe_out(oe),
        .core_reset_b_out(core_b), .port_latch_preset_out(), .ram_write_block_out(),
        .osc_default_out(), .fetch_enable_out(), .convert_start_b_out(cnv_out));

    reset_far_side reset_far_side_inst (.clk_in(clk_in), .press_in(press), .pin_oe_in(oe),
        .pin_drive_in(drv), .core_reset_b_in(core_b), .reset_pin_b_out(pin_b), .clock_stable_out(stab));

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (oe === 1'b1) oe_cnt <= oe_cnt + 1;
        if (cycles == 20000) begin
            err_total++;
            finish_test();
        end
    end

    function automatic logic [7:0] wdt_exp(input logic act, input logic [2:0] iv);
        return {3'h0, act, 1'b0, iv};
    endfunction

    function automatic logic [7:0] src_exp(input int k);
        return 8'h01 << k;
    endfunction

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // one bus cycle per call, so strobes are never set twice in a step
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
    endtask

    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
        idle(1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, 1'b1, a, 8'h00);
        idle(1);
        #1 chk(rdata, exp);
    endtask

    task automatic wait_core(input logic lvl, input int n, output logic hit);
        hit = 1'b0;
        for (int i = 0; i < n && !hit; i++) begin
            idle(1);
            #1 hit = (core_b === lvl);
        end
    endtask

    task automatic disarm(input int gap);
        bus(1'b1, 1'b0, ADDR_WATCHDOG_CTRL, WDT_CMD_DISARM1);
        idle(gap - 1);
        bus(1'b1, 1'b0, ADDR_WATCHDOG_CTRL, WDT_CMD_DISARM2);
        idle(1);
    endtask

    task automatic trip(input int k, input logic en);
        logic hit;
        int oe0;
        wr_reg(ADDR_RESET_SOURCE, (k > 1 && en) ? (8'h02 | src_exp(k)) : 8'h02);
        oe0 = oe_cnt;
        mon <= (k != 1) || en;
        press <= (k == 0);
        sok <= (k != 1);
        miss <= (k == 2);
        cmp <= (k != 5);
        cnv <= (k != 6);
        wait_core(1'b0, 20, hit);
        chk({7'h0, hit}, {7'h0, en});
        if (k == 6 && !en) chk({7'h0, cnv_out}, 8'h00);
        idle(20);
        {press, miss} <= 2'b00;
        {sok, mon, cmp, cnv} <= 4'hf;
        if (en) begin
            wait_core(1'b1, 400, hit);
            rd_chk(ADDR_RESET_SOURCE, src_exp(k));
            if (k != 0) chk({7'h0, oe_cnt != oe0}, {7'h0, k == 1});
        end
    endtask

    initial begin
        logic [7:0] r;
        logic hit;
        int oe0;
        void'($urandom(70103));
        {wr, rd, addr, wdata, press, miss} = '0;
        {sok, mon, cmp, cnv} = 4'hf;
        rst_b_in = 1'b0;
        repeat (16) @(posedge clk_in);
        rst_b_in <= 1'b1;
        wait_core(1'b1, 400, hit);
        chk({7'h0, hit}, 8'h01);
        rd_chk(ADDR_RESET_SOURCE, src_exp(1));
        rd_chk(ADDR_WATCHDOG_CTRL, wdt_exp(1'b1, WDT_INTERVAL_RESET));
        r = 8'($urandom_range(238));
        wr_reg(r, 8'h00);
        rd_chk(r, 8'h00);
        for (int g = 1; g <= 5; g++) begin
            wr_reg(ADDR_WATCHDOG_CTRL, WDT_CMD_KICK);
            disarm(g);
            rd_chk(ADDR_WATCHDOG_CTRL, wdt_exp(g > 4, 3'h7));
        end
        r = 8'($urandom);
        wr_reg(ADDR_WATCHDOG_CTRL, {1'b0, r[6:0]});
        wr_reg(ADDR_WATCHDOG_CTRL, {5'h10, ~r[2:0]});
        rd_chk(ADDR_WATCHDOG_CTRL, wdt_exp(1'b1, r[2:0]));
        wr_reg(ADDR_WATCHDOG_CTRL, 8'h00);
        wr_reg(ADDR_WATCHDOG_CTRL, WDT_CMD_KICK);
        idle(40);
        wr_reg(ADDR_WATCHDOG_CTRL, WDT_CMD_KICK);
        idle(40);
        chk({7'h0, core_b}, 8'h01);
        oe0 = oe_cnt;
        wr_reg(ADDR_WATCHDOG_CTRL, WDT_CMD_LOCK);
        disarm(1);
        rd_chk(ADDR_WATCHDOG_CTRL, wdt_exp(1'b1, 3'h0));
        wait_core(1'b0, 30, hit);
        chk({7'h0, hit}, 8'h01);
        wait_core(1'b1, 400, hit);
        chk({7'h0, oe_cnt != oe0}, 8'h00);
        rd_chk(ADDR_RESET_SOURCE, src_exp(3));
        rd_chk(ADDR_WATCHDOG_CTRL, wdt_exp(1'b1, WDT_INTERVAL_RESET));
        disarm(2);
        rd_chk(ADDR_WATCHDOG_CTRL, wdt_exp(1'b0, 3'h7));
        wr_reg(ADDR_WATCHDOG_CTRL, WDT_CMD_KICK);
        foreach (srcs[i]) begin
            for (int e = 0; e < 2; e++) begin
                if (srcs[i] != 0 || e == 1) trip(srcs[i], e[0]);
            end
        end
        finish_test();
    end
endmodule // reset_source_and_watchdog_tb_top

`default_nettype wire
